//--- hdl/udsr_pkg.sv
package udsr_pkg;

   // ------------------------------------------------------------------
   // Register offsets and field positions
   // ------------------------------------------------------------------
   localparam logic [3:0] OFS_RX_LOW   = 4'h0;
   localparam logic [3:0] OFS_RX_HIGH  = 4'h1;
   localparam logic [3:0] OFS_TX_LOW   = 4'h2;
   localparam logic [3:0] OFS_TX_HIGH  = 4'h3;
   localparam logic [3:0] OFS_STATUS   = 4'h4;
   localparam logic [3:0] OFS_CTRL_A   = 4'h5;

   localparam int ST_RXC = 7;
   localparam int ST_TXC = 6;
   localparam int ST_DRE = 5;
   localparam int ST_RXS = 4;
   localparam int ST_ISF = 3;
   localparam int ST_BDF = 1;
   localparam int ST_WFB = 0;

   localparam int CA_RECEIVE_COMPLETE_IRQ_ENABLE = 7;
   localparam int CA_TRANSMIT_COMPLETE_IRQ_ENABLE = 6;
   localparam int CA_BUFFER_EMPTY_IRQ_ENABLE = 5;
   localparam int CA_RECEIVE_START_IRQ_ENABLE = 4;
   localparam int CA_LOOPBACK_ENABLE  = 3;
   localparam int CA_AUTOBAUD_ERROR_IRQ_ENABLE = 2;

   // ------------------------------------------------------------------
   // Modes and encodings
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      RXM_NORMAL  = 2'h0,
      RXM_DOUBLE  = 2'h1,
      RXM_GENERIC_AUTOBAUD = 2'h2,
      RXM_LIN_CONSTRAINED_AUTOBAUD = 2'h3
   } udsr_rxmode_t;

   localparam logic [2:0] CS_5BIT    = 3'h0;
   localparam logic [2:0] CS_6BIT    = 3'h1;
   localparam logic [2:0] CS_7BIT    = 3'h2;
   localparam logic [2:0] CS_8BIT    = 3'h3;
   localparam logic [2:0] CS_9LOW    = 3'h6;
   localparam logic [2:0] CS_9HIGH   = 3'h7;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'h0,
      RX_START = 2'h1,
      RX_DATA  = 2'h2,
      RX_STOP  = 2'h3
   } udsr_rx_st_t;

   typedef enum logic [1:0] {
      AB_IDLE = 2'h0,
      AB_SYNC = 2'h1,
      AB_PID  = 2'h2,
      AB_RESP = 2'h3
   } udsr_ab_st_t;

   // ------------------------------------------------------------------
   // Timing counts, in system clock cycles (break length in bits), and control reset value
   // ------------------------------------------------------------------
   localparam logic [7:0] BIT_CYCLES  = 8'h10;
   localparam logic [7:0] BIT_HALF    = 8'h08;
   localparam logic [3:0] BREAK_BITS  = 4'hB;
   localparam logic [7:0] BIT_MIN     = 8'h04;
   localparam logic [7:0] BIT_MAX     = 8'hFF;
   localparam logic [7:0] CONTROL_REGISTER_A_RST   = 8'h00;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } udsr_bus_t;

   typedef struct packed {
      logic         rx_en;
      logic         tx_en;
      logic         sfd_en;
      logic         standby;
      logic         spi_master;
      udsr_rxmode_t rx_mode;
      logic [2:0]   char_size;
   } udsr_cfg_t;

   typedef struct packed {
      logic [7:0]       control_register_a;
      logic [7:0]       txb_lo;
      logic             txb_hi;
      logic             txb_full;
      logic             tx_hi_wait;
      logic             tx_busy;
      logic [3:0]       tx_bits;
      logic [7:0]       tx_cnt;
      logic [10:0]      tx_sh;
      logic             txd;
      logic             transmit_complete_flag;
      logic             buffer_empty_flag;
      logic             receive_start_flag;
      logic             inconsistent_sync_flag;
      logic             bdf;
      logic             wfb_arm;
      logic             wfb_low;
      logic             brk;
      logic             rx_prev;
      udsr_rx_st_t      rx_st;
      logic [7:0]       rx_cnt;
      logic [3:0]       rx_bit;
      logic [8:0]       rx_sh;
      logic [1:0][8:0]  fifo;
      logic             head;
      logic [1:0]       fcnt;
      udsr_ab_st_t      ab_st;
      logic [11:0]      low_cnt;
      logic [2:0]       edges;
      logic [11:0]      span;
      logic [9:0]       iv;
      logic             bad;
      logic [7:0]       bit_len;
      logic [7:0]       rdata;
   } udsr_state_t;

   localparam udsr_state_t STATE_RST = '{control_register_a: CONTROL_REGISTER_A_RST, buffer_empty_flag: 1'b1, txd: 1'b1, rx_prev: 1'b1,
                                         bit_len: BIT_CYCLES, rx_st: RX_IDLE, ab_st: AB_IDLE,
                                         default: '0};

endpackage : udsr_pkg

//--- hdl/udsr_core.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - LIN auto-baud: received ninth bit is 0 for identifier, 1 for response data.
// - Other modes: received ninth bit holds the ninth data bit in nine-bit frames.
// - Short characters: transmitter ignores upper bits, receiver returns them as zero.
// - Transmit low-byte write accepted only while buffer-empty flag set, else discarded.
// - Enabled transmitter moves buffer to empty shift register, then serialises it.
// - Transmit ninth bit used only in nine-bit size, never as SPI master.
// - Receive-complete flag shows unread data; receiver disable flushes buffer.
// - Transmit-complete sets when frame done and buffer empty; cleared by vector or 1.
// - Buffer-empty flag is 1 when buffer empty, 0 while holding data; set after reset.
// - Writing the transmit low byte clears the buffer-empty flag.
// - Start detection in standby sets receive-start flag; reads 0 when disabled; write 1 clears.
// - Inconsistent-sync flag sets on bad sync timing, or LIN sync not 0x55.
// - Writing 1 to inconsistent-sync clears it and idles auto-baud logic.
// - Auto-baud: break is 11 low bits; break flag sets after break plus sync.
// - Writing 1 to the break flag clears it.
// - Wait-for-break treats next low-then-high as break; bit reads zero.
// - Wait-for-break with generic auto-baud accepts any measured rate from BIT_MIN to BIT_MAX cycles per bit.
// - Interrupt request active while flag and enable both set, until flag cleared.
// - Receiver mode: 0 normal, 1 double, 2 generic auto-baud, 3 LIN auto-baud.
module udsr_core
   import udsr_pkg::*;
(
   input  wire logic       sys_clk_i,         // System clock, 40 MHz
   input  wire logic       rstn_i,            // Asynchronous reset, active low
   input  wire logic       ce_i,              // Clock enable, freezes all state when low
   input  wire udsr_bus_t  bus_i,             // Register port request
   output logic [7:0]      rdata_o,           // Read data, valid the cycle after a read
   input  wire udsr_cfg_t  cfg_i,             // Enables, receiver mode and character size
   input  wire logic       txc_vector_ack_i,  // Transmit-complete vector executed, one cycle
   input  wire logic       rxd_i,             // Serial receive line
   output logic            txd_o,             // Serial transmit line
   output logic            irq_rxc_o,         // Receive-side interrupt request
   output logic            irq_dre_o,         // Buffer-empty interrupt request
   output logic            irq_txc_o          // Transmit-complete interrupt request
);

   // ------------------------------------------------------------------
   // Derived signals
   // ------------------------------------------------------------------
   udsr_state_t s;
   udsr_state_t next_s;
   logic        rx_line;
   logic        fall;
   logic        rise;
   logic        auto_m;
   logic        lin_m;
   logic [7:0]  len;
   logic [3:0]  nbits;
   logic        low_first;
   logic        ninth_en;
   logic [8:0]  tx_word;
   logic [8:0]  rx_word;
   logic        rx_d8;
   logic        got;
   logic        tx_done;
   logic        rd_pop;
   logic [11:0] brk_lim;
   logic [9:0]  two_bits;
   logic [9:0]  tol;
   logic [11:0] span_now;
   logic        wr_st;
   logic [1:0]  fc;
   logic        fh;

   always_comb begin
      case (cfg_i.char_size)
         CS_5BIT:  nbits = 4'h5;
         CS_6BIT:  nbits = 4'h6;
         CS_7BIT:  nbits = 4'h7;
         CS_9LOW:  nbits = 4'h9;
         CS_9HIGH: nbits = 4'h9;
         default:  nbits = 4'h8;
      endcase
   end

   assign rx_line   = s.control_register_a[CA_LOOPBACK_ENABLE] ? s.txd : rxd_i;
   assign fall      = s.rx_prev & ~rx_line;
   assign rise      = ~s.rx_prev & rx_line;
   assign auto_m    = cfg_i.rx_mode[1];
   assign lin_m     = cfg_i.rx_mode == RXM_LIN_CONSTRAINED_AUTOBAUD;
   assign len       = auto_m ? s.bit_len : ((cfg_i.rx_mode == RXM_DOUBLE) ? BIT_HALF : BIT_CYCLES);
   assign low_first = cfg_i.char_size == CS_9LOW;
   assign ninth_en  = (nbits == 4'h9) && !cfg_i.spi_master;
   assign tx_word   = {ninth_en & s.txb_hi, s.txb_lo} & ~(9'h1FF << nbits);
   assign rx_word   = s.rx_sh >> (4'h9 - nbits);
   assign rx_d8     = lin_m ? (s.ab_st != AB_PID) : rx_word[8];
   assign got       = (s.rx_st == RX_STOP) && (s.rx_cnt == 8'h00) && rx_line;
   assign tx_done   = s.tx_busy && (s.tx_cnt == 8'h00) && (s.tx_bits == 4'h1);
   assign rd_pop    = bus_i.rd && (s.fcnt != 2'h0) && (bus_i.addr == (low_first ? OFS_RX_HIGH : OFS_RX_LOW));
   assign brk_lim   = 12'(len) * 12'(BREAK_BITS);
   assign two_bits  = {1'b0, len, 1'b0};
   assign tol       = 10'(len >> 2) + 10'(len >> 3);
   assign span_now  = s.span + 12'h001;
   assign wr_st     = bus_i.wr && (bus_i.addr == OFS_STATUS);

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      fc     = s.fcnt;
      fh     = s.head;
      next_s = s;
      next_s.rx_prev = rx_line;

      // Register reads; data stands for one cycle only.
      next_s.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            OFS_RX_LOW:  next_s.rdata = s.fifo[s.head][7:0];
            OFS_RX_HIGH: next_s.rdata = {s.fcnt != 2'h0, 6'h00, s.fifo[s.head][8]};
            OFS_TX_LOW:  next_s.rdata = s.txb_lo;
            OFS_TX_HIGH: next_s.rdata = {7'h00, s.txb_hi};
            OFS_STATUS:  next_s.rdata = {s.fcnt != 2'h0, s.transmit_complete_flag, s.buffer_empty_flag, s.receive_start_flag & cfg_i.sfd_en,
                                         s.inconsistent_sync_flag, 1'b0, s.bdf, 1'b0};
            OFS_CTRL_A:  next_s.rdata = s.control_register_a;
            default:     next_s.rdata = 8'h00;
         endcase
      end

      // Register writes. Flag clears come first so a same-cycle set wins.
      if (bus_i.wr) begin
         case (bus_i.addr)
            OFS_TX_LOW: begin
               if (s.buffer_empty_flag) begin
                  next_s.txb_lo     = bus_i.wdata;
                  next_s.txb_full   = 1'b1;
                  next_s.buffer_empty_flag      = 1'b0;
                  next_s.tx_hi_wait = low_first;
               end
            end
            OFS_TX_HIGH: begin
               // ninth bit completes a low-first pair
               next_s.txb_hi     = bus_i.wdata[0];
               next_s.tx_hi_wait = 1'b0;
            end
            OFS_STATUS: begin
               if (bus_i.wdata[ST_TXC]) next_s.transmit_complete_flag = 1'b0;
               if (bus_i.wdata[ST_RXS]) next_s.receive_start_flag = 1'b0;
               if (bus_i.wdata[ST_BDF]) next_s.bdf = 1'b0;
               if (bus_i.wdata[ST_WFB]) next_s.wfb_arm = 1'b1;
               if (bus_i.wdata[ST_ISF]) begin
                  next_s.inconsistent_sync_flag   = 1'b0;
                  next_s.ab_st   = AB_IDLE;
                  next_s.brk     = 1'b0;
                  next_s.edges   = 3'h0;
                  next_s.low_cnt = 12'h000;
               end
            end
            OFS_CTRL_A: next_s.control_register_a = bus_i.wdata;
            default: ;
         endcase
      end
      if (txc_vector_ack_i) next_s.transmit_complete_flag = 1'b0;

      // ---------------- Transmitter ----------------
      // load shift register when empty
      if (cfg_i.tx_en && s.txb_full && !s.tx_hi_wait && !s.tx_busy) begin
         next_s.tx_sh    = (11'(tx_word) << 1) | (11'h001 << (nbits + 4'h1));
         next_s.tx_bits  = nbits + 4'h2;
         next_s.tx_cnt   = len - 8'h01;
         next_s.tx_busy  = 1'b1;
         next_s.txd      = 1'b0;
         next_s.txb_full = 1'b0;
         next_s.buffer_empty_flag    = 1'b1;
      end else if (s.tx_busy) begin
         if (s.tx_cnt != 8'h00) begin
            next_s.tx_cnt = s.tx_cnt - 8'h01;
         end else if (tx_done) begin
            next_s.tx_busy = 1'b0;
            next_s.txd     = 1'b1;
            if (!s.txb_full) next_s.transmit_complete_flag = 1'b1;
         end else begin
            next_s.tx_sh   = s.tx_sh >> 1;
            next_s.txd     = s.tx_sh[1];
            next_s.tx_bits = s.tx_bits - 4'h1;
            next_s.tx_cnt  = len - 8'h01;
         end
      end

      // ---------------- Receiver ----------------
      case (s.rx_st)
         RX_IDLE: begin
            if (cfg_i.rx_en && fall && s.ab_st != AB_SYNC) begin
               next_s.rx_st  = RX_START;
               next_s.rx_cnt = len >> 1;
            end
         end
         RX_START: begin
            if (s.rx_cnt != 8'h00) begin
               next_s.rx_cnt = s.rx_cnt - 8'h01;
            end else begin
               next_s.rx_st  = rx_line ? RX_IDLE : RX_DATA;
               next_s.rx_cnt = len - 8'h01;
               next_s.rx_bit = 4'h0;
            end
         end
         RX_DATA: begin
            if (s.rx_cnt != 8'h00) begin
               next_s.rx_cnt = s.rx_cnt - 8'h01;
            end else begin
               next_s.rx_sh  = {rx_line, s.rx_sh[8:1]};
               next_s.rx_bit = s.rx_bit + 4'h1;
               next_s.rx_cnt = len - 8'h01;
               if (s.rx_bit == nbits - 4'h1) next_s.rx_st = RX_STOP;
            end
         end
         RX_STOP: begin
            if (s.rx_cnt != 8'h00) next_s.rx_cnt = s.rx_cnt - 8'h01;
            else next_s.rx_st = RX_IDLE;
         end
         default: next_s.rx_st = RX_IDLE;
      endcase

      // two-entry receive buffer; a character arriving while full is dropped.
      if (rd_pop) begin
         fh = ~s.head;
         fc = s.fcnt - 2'h1;
      end
      if (got) begin
         if (fc != 2'h2) begin
            next_s.fifo[fh ^ fc[0]] = {rx_d8, rx_word[7:0]};
            fc = fc + 2'h1;
         end
         // A same-cycle sync flag clear idles the auto-baud logic, so it wins here.
         if (s.ab_st == AB_PID && !(wr_st && bus_i.wdata[ST_ISF])) next_s.ab_st = AB_RESP;
         if (auto_m) next_s.bdf = 1'b0;
      end
      next_s.head = fh;
      next_s.fcnt = fc;

      if (cfg_i.sfd_en && cfg_i.standby && fall) next_s.receive_start_flag = 1'b1;

      // ---------------- Auto-baud ----------------
      if (auto_m && cfg_i.rx_en) begin
         next_s.low_cnt = rx_line ? 12'h000 : ((s.low_cnt == 12'hFFF) ? s.low_cnt : s.low_cnt + 12'h001);
         if (s.low_cnt >= brk_lim) next_s.brk = 1'b1;
         if (s.wfb_arm && !rx_line) next_s.wfb_low = 1'b1;
         if (rise && (s.brk || (s.wfb_arm && s.wfb_low))) begin
            next_s.ab_st   = AB_SYNC;
            next_s.brk     = 1'b0;
            next_s.wfb_arm = 1'b0;
            next_s.wfb_low = 1'b0;
            next_s.edges   = 3'h0;
            next_s.span    = 12'h000;
            next_s.iv      = 10'h000;
            next_s.bad     = 1'b0;
            next_s.rx_st   = RX_IDLE;
         end
         if (s.ab_st == AB_SYNC && s.edges != 3'h0) begin
            next_s.span = (s.span == 12'hFFF) ? s.span : span_now;
            next_s.iv   = (s.iv == 10'h3FF) ? s.iv : s.iv + 10'h001;
         end
         // Sync is 0x55: five falling edges two bit times apart, eight bit times first to last.
         if (s.ab_st == AB_SYNC && fall) begin
            next_s.edges = s.edges + 3'h1;
            next_s.iv    = 10'h000;
            // LIN: each two-bit interval must fit the local rate
            if (lin_m && s.edges != 3'h0 && (s.iv + tol < two_bits || s.iv > two_bits + tol)) begin
               next_s.bad = 1'b1;
            end
            if (s.edges == 3'h4) begin
               // in generic mode any rate from BIT_MIN to BIT_MAX cycles per bit is accepted
               if (span_now[11:3] >= 9'(BIT_MIN) && span_now[11:3] <= 9'(BIT_MAX) && !s.bad &&
                   !(lin_m && (s.iv + tol < two_bits || s.iv > two_bits + tol))) begin
                  next_s.bdf   = 1'b1;
                  next_s.ab_st = AB_PID;
                  if (!lin_m) next_s.bit_len = span_now[10:3];
               end else begin
                  next_s.inconsistent_sync_flag = 1'b1;
                  next_s.ab_st = AB_IDLE;
               end
            end
         end
      end

      // receiver disable flushes buffer and resets auto-baud
      if (!cfg_i.rx_en) begin
         next_s.fcnt    = 2'h0;
         next_s.rx_st   = RX_IDLE;
         next_s.ab_st   = AB_IDLE;
         next_s.low_cnt = 12'h000;
         next_s.brk     = 1'b0;
         next_s.wfb_low = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= STATE_RST;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign rdata_o   = s.rdata;
   assign txd_o     = s.txd;
   // request holds while flag and enable are set
   assign irq_rxc_o = (s.fcnt != 2'h0 && s.control_register_a[CA_RECEIVE_COMPLETE_IRQ_ENABLE]) || (s.receive_start_flag && cfg_i.sfd_en && s.control_register_a[CA_RECEIVE_START_IRQ_ENABLE])
                      || (s.inconsistent_sync_flag && s.control_register_a[CA_AUTOBAUD_ERROR_IRQ_ENABLE]);
   assign irq_dre_o = s.buffer_empty_flag && s.control_register_a[CA_BUFFER_EMPTY_IRQ_ENABLE];
   assign irq_txc_o = s.transmit_complete_flag && s.control_register_a[CA_TRANSMIT_COMPLETE_IRQ_ENABLE];

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   a_dre_write_clear: assert property (ce_i && bus_i.wr && bus_i.addr == OFS_TX_LOW && s.buffer_empty_flag |=> !s.buffer_empty_flag)
      else $error("buffer-empty flag not cleared by low byte write");
   a_tx_full_ignore: assert property (ce_i && bus_i.wr && bus_i.addr == OFS_TX_LOW && !s.buffer_empty_flag
                                      |=> s.txb_lo == $past(s.txb_lo))
      else $error("transmit buffer changed while full");
   a_rx_flush_on: assert property (ce_i && !cfg_i.rx_en |=> s.fcnt == 2'h0 && s.ab_st == AB_IDLE)
      else $error("receive buffer not flushed on disable");
   a_wfb_read_zero: assert property (ce_i && bus_i.rd && bus_i.addr == OFS_STATUS |=> rdata_o[ST_WFB] == 1'b0)
      else $error("wait-for-break read as one");
   a_txc_w1_clear: assert property (ce_i && wr_st && bus_i.wdata[ST_TXC] && !tx_done |=> !s.transmit_complete_flag)
      else $error("transmit-complete not cleared by write one");
   a_bdf_w1_clear: assert property (ce_i && wr_st && bus_i.wdata[ST_BDF] && s.ab_st != AB_SYNC |=> !s.bdf)
      else $error("break flag not cleared by write one");
   a_txc_irq_hold: assert property (s.transmit_complete_flag && s.control_register_a[CA_TRANSMIT_COMPLETE_IRQ_ENABLE] && !txc_vector_ack_i && !wr_st && !bus_i.wr
                                    |=> irq_txc_o)
      else $error("transmit-complete request dropped while flag set");
   a_load_tx_frame: assert property (ce_i && cfg_i.tx_en && s.txb_full && !s.tx_hi_wait && !s.tx_busy
                                     |=> s.buffer_empty_flag && s.tx_busy && !txd_o)
      else $error("buffered data not moved to shift register");
   a_isf_to_idle: assert property (ce_i && wr_st && bus_i.wdata[ST_ISF] && s.ab_st != AB_SYNC && !s.brk
                                   && !s.wfb_arm |=> s.ab_st == AB_IDLE && !s.inconsistent_sync_flag)
      else $error("auto-baud not idled by sync flag clear");
   a_lin_pid_zero: assert property (ce_i && cfg_i.rx_en && got && lin_m && s.ab_st == AB_PID && !wr_st
                                    |-> !rx_d8 ##1 s.ab_st == AB_RESP)
      else $error("identifier ninth bit not zero");
   a_sfd_off_zero: assert property (ce_i && bus_i.rd && bus_i.addr == OFS_STATUS && !cfg_i.sfd_en
                                    |=> rdata_o[ST_RXS] == 1'b0)
      else $error("receive-start flag read while detection off");
   a_short_upper: assert property (got && cfg_i.char_size == CS_5BIT |-> rx_word[8:5] == 4'h0)
      else $error("short character upper bits not zero");

endmodule : udsr_core

//--- tb/udsr_node.sv
`timescale 1ns/1ps
module udsr_node
   import udsr_pkg::*;
(
   input  wire logic sys_clk_i,  // System clock
   input  wire logic txd_i,      // Line driven by the block
   output logic      rxd_o       // Line into the block, idle high
);
   // ---------------------------------------------------------------
   // Far serial node, one bit length per bit, LSB first
   // ---------------------------------------------------------------
   initial rxd_o = 1'b1;

   task automatic send(input logic [8:0] d, input int n);
      @(posedge sys_clk_i);
      rxd_o <= 1'b0;
      repeat (BIT_CYCLES) @(posedge sys_clk_i);
      for (int i = 0; i < n; i++) begin
         rxd_o <= d[i];
         repeat (BIT_CYCLES) @(posedge sys_clk_i);
      end
      rxd_o <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
   endtask : send

   // Holds the line low for n cycles, as a break, then releases it.
   task automatic hold_low(input int n);
      @(posedge sys_clk_i);
      rxd_o <= 1'b0;
      repeat (n) @(posedge sys_clk_i);
      rxd_o <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
   endtask : hold_low

   // Samples mid-bit so that edge jitter of one cycle cannot flip a bit.
   task automatic get(input int n, output logic [8:0] d);
      d = '0;
      wait (txd_i === 1'b0);
      repeat (BIT_HALF) @(posedge sys_clk_i);
      for (int i = 0; i < n; i++) begin
         repeat (BIT_CYCLES) @(posedge sys_clk_i);
         d[i] = txd_i;
      end
   endtask : get
endmodule : udsr_node

//--- tb/udsr_core_tb.sv
`timescale 1ns/1ps
module udsr_core_tb
   import udsr_pkg::*;
;
   // ---------------------------------------------------------------
   // Register and serial scenarios
   // ---------------------------------------------------------------
   logic       sys_clk_i, rstn_i, ce, ack, rxd, txd, irq_rxc, irq_dre, irq_txc;
   udsr_bus_t  bus;
   udsr_cfg_t  cfg;
   logic [7:0] rdata;
   logic [8:0] got;
   int         fail_count = 0, n_checks = 0, cyc = 0;

   udsr_core udsr_core_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce), .bus_i(bus),
      .rdata_o(rdata), .cfg_i(cfg), .txc_vector_ack_i(ack), .rxd_i(rxd), .txd_o(txd),
      .irq_rxc_o(irq_rxc), .irq_dre_o(irq_dre), .irq_txc_o(irq_txc));
   udsr_node udsr_node_inst (.sys_clk_i(sys_clk_i), .txd_i(txd), .rxd_o(rxd));

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_i);
      bus.wr <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe, so it is taken there.
   task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string nm);
      @(posedge sys_clk_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_i);
      bus.rd <= 1'b0;
      #1 chk(nm, {1'b0, e}, {1'b0, rdata});
   endtask : rchk

   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      rstn_i = 1'b0;
      bus = '0;
      ack = 1'b0;
      ce = 1'b1;
      cfg = '0;
      cfg.rx_en = 1'b1;
      cfg.char_size = CS_8BIT;
      repeat (10) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      rchk(OFS_STATUS, 8'h20, "status");
      rchk(OFS_CTRL_A, 8'h00, "control_register_a");
      wr(OFS_CTRL_A, 8'hFF);
      rchk(OFS_CTRL_A, 8'hFF, "control_register_a");
      chk("irq_dre", 9'h001, {8'h00, irq_dre});
      ce <= 1'b0;
      wr(OFS_CTRL_A, 8'h5A);
      ce <= 1'b1;
      rchk(OFS_CTRL_A, 8'hFF, "control_register_a_frozen");
      wr(OFS_CTRL_A, 8'h00);
      wr(OFS_TX_HIGH, 8'hFF);
      rchk(OFS_TX_HIGH, 8'h01, "tx_high");
      wr(OFS_STATUS, 8'h05);
      rchk(OFS_STATUS, 8'h20, "status");
      wr(OFS_TX_LOW, 8'hA5);
      rchk(OFS_STATUS, 8'h00, "status");
      wr(OFS_TX_LOW, 8'h3C);
      fork
         udsr_node_inst.get(8, got);
         cfg.tx_en <= 1'b1;
      join
      chk("tx_byte", 9'h0A5, got);
      repeat (40) @(posedge sys_clk_i);
      rchk(OFS_STATUS, 8'h60, "status");
      wr(OFS_CTRL_A, 8'h40);
      #1 chk("irq_txc", 9'h001, {8'h00, irq_txc});
      @(posedge sys_clk_i) ack <= 1'b1;
      @(posedge sys_clk_i) ack <= 1'b0;
      rchk(OFS_STATUS, 8'h20, "status");
      chk("irq_txc", 9'h000, {8'h00, irq_txc});
      cfg.char_size <= CS_5BIT;
      fork
         udsr_node_inst.get(5, got);
         wr(OFS_TX_LOW, 8'hFF);
      join
      chk("tx_short", 9'h01F, got);
      repeat (40) @(posedge sys_clk_i);
      cfg.char_size <= CS_9HIGH;
      fork
         udsr_node_inst.get(9, got);
         begin
            wr(OFS_TX_HIGH, 8'h01);
            wr(OFS_TX_LOW, 8'h55);
         end
      join
      chk("tx_nine", 9'h155, got);
      repeat (40) @(posedge sys_clk_i);
      wr(OFS_STATUS, 8'h40);
      udsr_node_inst.send(9'h1A5, 9);
      wr(OFS_CTRL_A, 8'h80);
      #1 chk("irq_rxc", 9'h001, {8'h00, irq_rxc});
      rchk(OFS_RX_HIGH, 8'h81, "rx_high");
      rchk(OFS_RX_LOW, 8'hA5, "rx_low");
      rchk(OFS_STATUS, 8'h20, "status");
      chk("irq_rxc", 9'h000, {8'h00, irq_rxc});
      cfg.char_size <= CS_5BIT;
      udsr_node_inst.send(9'h1FF, 5);
      rchk(OFS_RX_LOW, 8'h1F, "rx_short");
      udsr_node_inst.send(9'h00A, 5);
      cfg.rx_en <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rchk(OFS_STATUS, 8'h20, "status");
      cfg.rx_en <= 1'b1;
      cfg.rx_mode <= RXM_LIN_CONSTRAINED_AUTOBAUD;
      cfg.char_size <= CS_8BIT;
      udsr_node_inst.hold_low(200);
      udsr_node_inst.send(9'h055, 8);
      rchk(OFS_STATUS, 8'h22, "status_lin");
      udsr_node_inst.send(9'h03C, 8);
      udsr_node_inst.send(9'h0A7, 8);
      rchk(OFS_RX_HIGH, 8'h80, "rx_pid");
      rchk(OFS_RX_LOW, 8'h3C, "rx_low");
      rchk(OFS_RX_HIGH, 8'h81, "rx_resp");
      rchk(OFS_RX_LOW, 8'hA7, "rx_low");
      rchk(OFS_STATUS, 8'h20, "status");
      wr(OFS_STATUS, 8'h08);
      cfg.rx_mode <= RXM_GENERIC_AUTOBAUD;
      udsr_node_inst.hold_low(200);
      udsr_node_inst.send(9'h055, 8);
      rchk(OFS_STATUS, 8'h22, "status_gen");
      wr(OFS_STATUS, 8'h02);
      rchk(OFS_STATUS, 8'h20, "status");
      close_out();
   end
endmodule : udsr_core_tb
